// >>> inc/wtc_cfg.svh
`ifndef WTC_CFG_SVH
`define WTC_CFG_SVH

// ----------------------------------------------------------------
// Register offsets within the relocatable 2-Kbyte region
// ----------------------------------------------------------------
`define WTC_ADDR_W 16
`define WTC_OFS_W 11
`define WTC_BASE_W 5
`define WTC_OFS_TICK_CTL 11'h014
`define WTC_OFS_TICK_FLAG 11'h015
`define WTC_OFS_SUP_CTL 11'h016
`define WTC_OFS_SERVICE 11'h017
`define WTC_OFS_WAIT_DIV 11'h0E0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WTC_TC_IRQ_EN 7
`define WTC_TC_HALT_WAIT 6
`define WTC_TC_HALT_DBG 5
`define WTC_TC_BYPASS 3
`define WTC_FLAG_BIT 7
`define WTC_SC_CM_EN 7
`define WTC_SC_CM_FORCE_EN 6
`define WTC_SC_CM_FORCE_RST 5
`define WTC_SC_WD_FORCE_RST 4
`define WTC_SC_RST_DIS 3

// ----------------------------------------------------------------
// Reset values and service values
// ----------------------------------------------------------------
`define WTC_RST_TICK_CTL 8'h00
`define WTC_RST_SUP_CTL 8'h01
`define WTC_RST_WAIT_DIV 8'h00
`define WTC_SVC_FIRST_VAL 8'h55
`define WTC_SVC_SECOND_VAL 8'hAA

// ----------------------------------------------------------------
// Divider stage counts
// ----------------------------------------------------------------
`define WTC_PRESCALE_STAGES 5'd13
`define WTC_BYPASS_STAGES 5'd2
`define WTC_WD_CNT_W 23
`define WTC_TICK_CNT_W 19
`define WTC_SLOW_CNT_W 7

`endif

// >>> inc/wtc_pkg.sv
package wtc_pkg;

  // Watchdog service sequence tracker
  typedef enum logic [1:0]
  {
    WTC_SVC_AWAIT_FIRST = 2'b01,
    WTC_SVC_AWAIT_SECOND = 2'b10
  } wtc_svc_e;

  typedef logic [7:0] wtc_byte_t;
  typedef logic [2:0] wtc_rate_t;
  typedef logic [4:0] wtc_stage_t;

endpackage : wtc_pkg

// >>> design/wtc_clock_monitor.sv
`timescale 1ns/10ps
`include "wtc_cfg.svh"

module wtc_clock_monitor
  import wtc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic monitor_active,
  input wire logic force_reset,
  input wire logic reset_disable,
  input wire logic rc_timeout_pin,
  output logic timeout_seen,
  output logic monitor_reset
);

  // ----------------------------------------------------------------
  // Synchroniser for the RC delay detector
  // ----------------------------------------------------------------
  logic rc_meta_reg;
  logic rc_sync_reg;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rc_meta_reg <= 1'b0;
      rc_sync_reg <= 1'b0;
    end
    else
    begin
      rc_meta_reg <= rc_timeout_pin;
      rc_sync_reg <= rc_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Reset request
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      timeout_seen <= 1'b0;
      monitor_reset <= 1'b0;
    end
    else
    begin
      timeout_seen <= rc_sync_reg;
      monitor_reset <= monitor_active & ~reset_disable
        & (rc_sync_reg | force_reset);
    end
  end

endmodule : wtc_clock_monitor

// >>> design/wtc_top.sv
`timescale 1ns/10ps
`include "wtc_cfg.svh"

// Summary of operation
// - Enabled watchdog needs first then second service value before timeout.
// - Any other service register value causes an immediate system reset.
// - Three-bit watchdog rate picks disabled or one of seven periods.
// - Tick rate zero stops tick; codes 1..7 divide by 2^13..2^19.
// - Tick interrupt requested while flag and enable are both one.
// - Tick flag in bit 7 sets on period, clears by writing one.
// - Halt-in-wait stops tick and watchdog in wait; write-once normally.
// - Halt-in-debug stops tick and watchdog in debug; write-once normally.
// - Bypass test bit, special modes only, makes prescaler divide by 4.
// - Slow divisor x divides bus clock by 2^x; zero bypasses.
// - Enabled clock monitor resets on RC timeout, sampled through a core_clk synchroniser.
// - Monitor enable writable anytime; ignored while force-enable set.
// - Force-enable write-once normally; then monitor active until reset.
// - Force-monitor-reset bit, special modes only, forces monitor reset if monitor active.
// - Tick divider runs on core_clk, not slowed by the wait divider; tick rate writable anytime.
// - Register group relocates as a unit to any aligned 2-Kbyte region.
// - Watchdog stages 13,15,17,19,21,22,23; rate write-once normally.
// - Reset-disable blocks watchdog and monitor resets; special-mode write.
// - Force-watchdog-reset bit, special modes only, forces watchdog reset if watchdog enabled.
// - Slow divider acts only in wait mode, else clock unchanged.

module wtc_top
  import wtc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [`WTC_BASE_W-1:0] reg_base,
  input wire logic [`WTC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic special_mode,
  input wire logic wait_mode,
  input wire logic debug_mode,
  input wire logic rc_timeout_pin,
  output logic tick_irq,
  output logic watchdog_reset,
  output logic monitor_reset,
  output logic bus_clk_enable
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic wtc_stage_t wd_stages(input wtc_rate_t code);
    wtc_stage_t s;
    s = 5'd0;
    case (code)
      3'd1: s = 5'd13;
      3'd2: s = 5'd15;
      3'd3: s = 5'd17;
      3'd4: s = 5'd19;
      3'd5: s = 5'd21;
      3'd6: s = 5'd22;
      3'd7: s = 5'd23;
      default: s = 5'd0;
    endcase
    return s;
  endfunction : wd_stages

  // Prescaler shortened by the bypass test bit
  function automatic wtc_stage_t eff_stages(input wtc_stage_t s,
                                            input logic bypass);
    wtc_stage_t r;
    r = s;
    if (bypass)
    begin
      r = s - `WTC_PRESCALE_STAGES + `WTC_BYPASS_STAGES;
    end
    return r;
  endfunction : eff_stages

  // Terminal count of a divider with the given number of stages
  function automatic logic [`WTC_WD_CNT_W-1:0] term_count(
    input wtc_stage_t s);
    logic [`WTC_WD_CNT_W:0] t;
    t = ({{`WTC_WD_CNT_W{1'b0}}, 1'b1} << s) - 1'b1;
    return t[`WTC_WD_CNT_W-1:0];
  endfunction : term_count

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic in_region;
  logic [`WTC_OFS_W-1:0] ofs;
  logic sel_tick_ctl;
  logic sel_tick_flag;
  logic sel_sup_ctl;
  logic sel_service;
  logic sel_wait_div;

  assign in_region = (reg_addr[`WTC_ADDR_W-1:`WTC_OFS_W] == reg_base);
  assign ofs = reg_addr[`WTC_OFS_W-1:0];

  always_comb
  begin
    sel_tick_ctl = 1'b0;
    sel_tick_flag = 1'b0;
    sel_sup_ctl = 1'b0;
    sel_service = 1'b0;
    sel_wait_div = 1'b0;
    if (!in_region)
    begin
      sel_tick_ctl = 1'b0;
    end
    else if (ofs == `WTC_OFS_TICK_CTL)
    begin
      sel_tick_ctl = 1'b1;
    end
    else if (ofs == `WTC_OFS_TICK_FLAG)
    begin
      sel_tick_flag = 1'b1;
    end
    else if (ofs == `WTC_OFS_SUP_CTL)
    begin
      sel_sup_ctl = 1'b1;
    end
    else if (ofs == `WTC_OFS_SERVICE)
    begin
      sel_service = 1'b1;
    end
    else if (ofs == `WTC_OFS_WAIT_DIV)
    begin
      sel_wait_div = 1'b1;
    end
  end

  logic wr_tick_ctl;
  logic wr_tick_flag;
  logic wr_sup_ctl;
  logic wr_service;
  logic wr_wait_div;

  assign wr_tick_ctl = reg_wr & sel_tick_ctl;
  assign wr_tick_flag = reg_wr & sel_tick_flag;
  assign wr_sup_ctl = reg_wr & sel_sup_ctl;
  assign wr_service = reg_wr & sel_service;
  assign wr_wait_div = reg_wr & sel_wait_div;

  // ----------------------------------------------------------------
  // Tick control register
  // ----------------------------------------------------------------
  wtc_byte_t tick_ctl_reg;
  logic halt_wait_locked_reg;
  logic halt_dbg_locked_reg;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tick_ctl_reg <= `WTC_RST_TICK_CTL;
      halt_wait_locked_reg <= 1'b0;
      halt_dbg_locked_reg <= 1'b0;
    end
    else if (wr_tick_ctl)
    begin
      tick_ctl_reg[`WTC_TC_IRQ_EN] <= reg_wdata[`WTC_TC_IRQ_EN];
      tick_ctl_reg[2:0] <= reg_wdata[2:0];
      if (special_mode || !halt_wait_locked_reg)
      begin
        tick_ctl_reg[`WTC_TC_HALT_WAIT] <= reg_wdata[`WTC_TC_HALT_WAIT];
      end
      if (special_mode || !halt_dbg_locked_reg)
      begin
        tick_ctl_reg[`WTC_TC_HALT_DBG] <= reg_wdata[`WTC_TC_HALT_DBG];
      end
      if (special_mode)
      begin
        tick_ctl_reg[`WTC_TC_BYPASS] <= reg_wdata[`WTC_TC_BYPASS];
      end
      halt_wait_locked_reg <= halt_wait_locked_reg | ~special_mode;
      halt_dbg_locked_reg <= halt_dbg_locked_reg | ~special_mode;
    end
  end

  logic tick_irq_en;
  logic bypass;
  wtc_rate_t tick_rate;
  logic halted;

  assign tick_irq_en = tick_ctl_reg[`WTC_TC_IRQ_EN];
  assign bypass = tick_ctl_reg[`WTC_TC_BYPASS];
  assign tick_rate = tick_ctl_reg[2:0];
  assign halted = (tick_ctl_reg[`WTC_TC_HALT_WAIT] & wait_mode)
    | (tick_ctl_reg[`WTC_TC_HALT_DBG] & debug_mode);

  // ----------------------------------------------------------------
  // Supervisor control register
  // ----------------------------------------------------------------
  wtc_byte_t sup_ctl_reg;
  logic force_en_locked_reg;
  logic wd_rate_locked_reg;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sup_ctl_reg <= `WTC_RST_SUP_CTL;
      force_en_locked_reg <= 1'b0;
      wd_rate_locked_reg <= 1'b0;
    end
    else if (wr_sup_ctl)
    begin
      sup_ctl_reg[`WTC_SC_CM_EN] <= reg_wdata[`WTC_SC_CM_EN];
      if (special_mode || !force_en_locked_reg)
      begin
        sup_ctl_reg[`WTC_SC_CM_FORCE_EN] <= reg_wdata[`WTC_SC_CM_FORCE_EN];
      end
      if (special_mode)
      begin
        sup_ctl_reg[`WTC_SC_CM_FORCE_RST] <= reg_wdata[`WTC_SC_CM_FORCE_RST];
        sup_ctl_reg[`WTC_SC_WD_FORCE_RST] <= reg_wdata[`WTC_SC_WD_FORCE_RST];
        sup_ctl_reg[`WTC_SC_RST_DIS] <= reg_wdata[`WTC_SC_RST_DIS];
      end
      if (special_mode || !wd_rate_locked_reg)
      begin
        sup_ctl_reg[2:0] <= reg_wdata[2:0];
      end
      force_en_locked_reg <= force_en_locked_reg | ~special_mode;
      wd_rate_locked_reg <= wd_rate_locked_reg | ~special_mode;
    end
  end

  logic reset_disable;
  logic monitor_active;
  wtc_rate_t wd_rate;

  assign reset_disable = sup_ctl_reg[`WTC_SC_RST_DIS];
  assign wd_rate = sup_ctl_reg[2:0];
  assign monitor_active = sup_ctl_reg[`WTC_SC_CM_FORCE_EN]
    | sup_ctl_reg[`WTC_SC_CM_EN];

  // ----------------------------------------------------------------
  // Wait clock divisor register
  // ----------------------------------------------------------------
  wtc_byte_t wait_div_reg;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wait_div_reg <= `WTC_RST_WAIT_DIV;
    end
    else if (wr_wait_div)
    begin
      wait_div_reg <= {5'd0, reg_wdata[2:0]};
    end
  end

  // ----------------------------------------------------------------
  // Periodic tick divider and flag
  // ----------------------------------------------------------------
  logic [`WTC_TICK_CNT_W-1:0] tick_cnt_reg;
  logic [`WTC_WD_CNT_W-1:0] tick_term;
  logic tick_fire;
  logic tick_flag_reg;

  assign tick_term = term_count(eff_stages(
    5'(tick_rate) + 5'd12, bypass));
  assign tick_fire = (tick_rate != 3'd0) && !halted
    && ({4'd0, tick_cnt_reg} >= tick_term);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_reg <= '0;
    end
    else if (tick_rate == 3'd0)
    begin
      tick_cnt_reg <= '0;
    end
    else if (!halted)
    begin
      if (tick_fire)
      begin
        tick_cnt_reg <= '0;
      end
      else
      begin
        tick_cnt_reg <= tick_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tick_flag_reg <= 1'b0;
    end
    else if (tick_fire)
    begin
      tick_flag_reg <= 1'b1;
    end
    else if (wr_tick_flag && reg_wdata[`WTC_FLAG_BIT])
    begin
      tick_flag_reg <= 1'b0;
    end
  end

  assign tick_irq = tick_flag_reg & tick_irq_en;

  // ----------------------------------------------------------------
  // Watchdog service sequence and counter
  // ----------------------------------------------------------------
  wtc_svc_e svc_state_reg;
  logic svc_done;
  logic svc_bad;
  logic [`WTC_WD_CNT_W-1:0] wd_cnt_reg;
  logic [`WTC_WD_CNT_W-1:0] wd_term;
  logic wd_enabled;
  logic wd_timeout;

  assign svc_done = wr_service && (svc_state_reg == WTC_SVC_AWAIT_SECOND)
    && (reg_wdata == `WTC_SVC_SECOND_VAL);
  assign svc_bad = wr_service && (reg_wdata != `WTC_SVC_FIRST_VAL)
    && (reg_wdata != `WTC_SVC_SECOND_VAL);
  assign wd_enabled = (wd_rate != 3'd0);
  assign wd_term = term_count(eff_stages(wd_stages(wd_rate), bypass));
  assign wd_timeout = wd_enabled && !halted && (wd_cnt_reg >= wd_term);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      svc_state_reg <= WTC_SVC_AWAIT_FIRST;
    end
    else if (wr_service)
    begin
      case (svc_state_reg)
        WTC_SVC_AWAIT_FIRST:
        begin
          if (reg_wdata == `WTC_SVC_FIRST_VAL)
          begin
            svc_state_reg <= WTC_SVC_AWAIT_SECOND;
          end
        end
        WTC_SVC_AWAIT_SECOND:
        begin
          if (reg_wdata == `WTC_SVC_SECOND_VAL)
          begin
            svc_state_reg <= WTC_SVC_AWAIT_FIRST;
          end
        end
        default:
        begin
          svc_state_reg <= WTC_SVC_AWAIT_FIRST;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wd_cnt_reg <= '0;
    end
    else if (!wd_enabled || svc_done)
    begin
      wd_cnt_reg <= '0;
    end
    else if (!halted)
    begin
      if (wd_timeout)
      begin
        wd_cnt_reg <= '0;
      end
      else
      begin
        wd_cnt_reg <= wd_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      watchdog_reset <= 1'b0;
    end
    else
    begin
      watchdog_reset <= !reset_disable && (wd_timeout || svc_bad
        || (wd_enabled && sup_ctl_reg[`WTC_SC_WD_FORCE_RST]));
    end
  end

  // ----------------------------------------------------------------
  // Clock monitor
  // ----------------------------------------------------------------
  logic monitor_timeout_seen;

  wtc_clock_monitor u_monitor
  (
    .core_clk(core_clk),
    .rst(rst),
    .monitor_active(monitor_active),
    .force_reset(sup_ctl_reg[`WTC_SC_CM_FORCE_RST]),
    .reset_disable(reset_disable),
    .rc_timeout_pin(rc_timeout_pin),
    .timeout_seen(monitor_timeout_seen),
    .monitor_reset(monitor_reset)
  );

  // ----------------------------------------------------------------
  // Wait-mode bus clock slow-down
  // ----------------------------------------------------------------
  logic [`WTC_SLOW_CNT_W-1:0] slow_cnt_reg;
  logic [`WTC_SLOW_CNT_W-1:0] slow_term;
  logic slow_on;

  assign slow_on = wait_mode && (wait_div_reg[2:0] != 3'd0);
  assign slow_term = 7'((8'd1 << wait_div_reg[2:0]) - 8'd1);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      slow_cnt_reg <= '0;
      bus_clk_enable <= 1'b1;
    end
    else if (!slow_on)
    begin
      slow_cnt_reg <= '0;
      bus_clk_enable <= 1'b1;
    end
    else if (slow_cnt_reg >= slow_term)
    begin
      slow_cnt_reg <= '0;
      bus_clk_enable <= 1'b1;
    end
    else
    begin
      slow_cnt_reg <= slow_cnt_reg + 1'b1;
      bus_clk_enable <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
    end
    else if (!reg_rd)
    begin
      reg_rdata <= 8'h00;
    end
    else if (sel_tick_ctl)
    begin
      reg_rdata <= {tick_ctl_reg[7:5], 1'b0, tick_ctl_reg[3:0]};
    end
    else if (sel_tick_flag)
    begin
      reg_rdata <= {tick_flag_reg, 7'd0};
    end
    else if (sel_sup_ctl)
    begin
      reg_rdata <= sup_ctl_reg;
    end
    else if (sel_wait_div)
    begin
      reg_rdata <= wait_div_reg;
    end
    else
    begin
      reg_rdata <= 8'h00;
    end
  end

  // Monitor status kept for debug visibility
  logic unused_timeout_seen;
  assign unused_timeout_seen = monitor_timeout_seen;

endmodule : wtc_top

// >>> verification/wtc_monitor.sv
`timescale 1ns/10ps
`include "wtc_cfg.svh"

// ----------------
// Port checker
// ----------------
module wtc_monitor
  import wtc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [`WTC_BASE_W-1:0] reg_base,
  input wire logic [`WTC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic special_mode,
  input wire logic wait_mode,
  input wire logic debug_mode,
  input wire logic rc_timeout_pin,
  input wire logic tick_irq,
  input wire logic watchdog_reset,
  input wire logic monitor_reset,
  input wire logic bus_clk_enable
);
  logic hit;
  logic [10:0] ofs;
  logic [2:0] div_reg;
  logic svc_wr;
  logic svc_ok;

  assign hit = reg_addr[15:11] == reg_base;
  assign ofs = reg_addr[10:0];
  assign svc_wr = reg_wr && hit && ofs == `WTC_OFS_SERVICE && !special_mode;
  assign svc_ok = reg_wdata == 8'h55 || reg_wdata == 8'hAA;

  // Shadow of the wait divisor field
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      div_reg <= 3'h0;
    else if (reg_wr && hit && ofs == `WTC_OFS_WAIT_DIV)
      div_reg <= reg_wdata[2:0];
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ----------------
  // Assertions
  // ----------------
  AST_IRQ_OFF:
    assert property (reg_wr && hit && ofs == `WTC_OFS_TICK_CTL &&
      !reg_wdata[7] |=> !tick_irq) else $error("irq with enable clear");
  AST_RDATA_IDLE:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
  AST_FLAG_READ:
    assert property (reg_rd && hit && ofs == `WTC_OFS_TICK_FLAG |=>
      reg_rdata[6:0] == 7'h00) else $error("flag register low bits set");
  AST_SVC_READ:
    assert property (reg_rd && hit && ofs == `WTC_OFS_SERVICE |=>
      reg_rdata == 8'h00) else $error("service register read not zero");
  AST_OUT_REGION:
    assert property (reg_rd && !hit |=> reg_rdata == 8'h00)
      else $error("read outside region not zero");
  AST_BAD_SVC:
    assert property (svc_wr && !svc_ok |=> watchdog_reset)
      else $error("no reset after bad service value");
  AST_GOOD_SVC:
    assert property (svc_wr && svc_ok |=> !watchdog_reset)
      else $error("reset after service value");
  AST_SLOW:
    assert property (!wait_mode || div_reg == 3'h0 |=> bus_clk_enable)
      else $error("bus clock gated outside slow mode");
  AST_MON_CAUSE:
    assert property ($rose(monitor_reset) && !special_mode |->
      $past(rc_timeout_pin, 3)) else $error("monitor reset without timeout");

  COV_TICK: cover property ($rose(tick_irq));
  COV_WD: cover property ($rose(watchdog_reset));
  COV_CM: cover property ($rose(monitor_reset));
  COV_SLOW: cover property ($fell(bus_clk_enable));
endmodule : wtc_monitor

// >>> verification/tb.sv
`timescale 1ns/10ps
`include "wtc_cfg.svh"

// ----------------
// Bench
// ----------------
module tb
  import wtc_pkg::*;
();
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] reg_base = 5'h03;
  logic [4:0] base = 5'h03;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic special_mode = 1'b0;
  logic wait_mode = 1'b0;
  logic debug_mode = 1'b0;
  logic rc_timeout_pin = 1'b0;
  logic [7:0] reg_rdata;
  logic tick_irq, watchdog_reset, monitor_reset, bus_clk_enable;
  logic [2:0] outs;
  int num_errors = 0;
  int comparisons = 0;
  int n;
  int p;
  int st[8] = '{0, 13, 15, 17, 19, 21, 22, 23};

  assign outs = {monitor_reset, watchdog_reset, tick_irq};
  always #10 core_clk = ~core_clk;

  wtc_top DUT (.core_clk(core_clk), .rst(rst), .reg_base(reg_base),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .special_mode(special_mode),
    .wait_mode(wait_mode), .debug_mode(debug_mode),
    .rc_timeout_pin(rc_timeout_pin), .tick_irq(tick_irq),
    .watchdog_reset(watchdog_reset), .monitor_reset(monitor_reset),
    .bus_clk_enable(bus_clk_enable));

  task automatic results;
  begin
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask : results

  task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
  begin
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  end
  endtask : cmp

  task automatic cmpn(input string s, input int lo, input int hi, input int g);
  begin
    comparisons++;
    if (g < lo || g > hi)
    begin
      num_errors++;
      $display("mismatch %s exp %0d..%0d got %0d", s, lo, hi, g);
    end
  end
  endtask : cmpn

  task automatic wr(input logic [10:0] o, input logic [7:0] d);
  begin
    reg_addr <= {base, o};
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  end
  endtask : wr

  task automatic rd(input logic [10:0] o, input logic [7:0] e);
  begin
    reg_addr <= {base, o};
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    cmp($sformatf("read %h", o), e, reg_rdata);
  end
  endtask : rd

  task automatic wait_hi(input int k, input int lim);
  begin
    n = 0;
    while (outs[k] !== 1'b1 && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= lim)
    begin
      num_errors++;
      $display("mismatch wait %0d exp 1 got 0", k);
      results();
    end
  end
  endtask : wait_hi

  task automatic do_reset(input logic sm);
  begin
    rst <= 1'b1;
    special_mode <= sm;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
  end
  endtask : do_reset

  initial
  begin
    do_reset(1'b0);
    cmp("outs", 8'h01, {4'h0, outs, bus_clk_enable});
    rd(`WTC_OFS_TICK_CTL, 8'h00);
    rd(`WTC_OFS_TICK_FLAG, 8'h00);
    rd(`WTC_OFS_SUP_CTL, 8'h01);
    rd(`WTC_OFS_SERVICE, 8'h00);
    rd(`WTC_OFS_WAIT_DIV, 8'h00);
    rd(11'h100, 8'h00);
    base = 5'h0A;
    rd(`WTC_OFS_SUP_CTL, 8'h00);
    base = 5'h03;
    $display("test reset done");
    wr(`WTC_OFS_SERVICE, 8'hAA);
    wr(`WTC_OFS_SERVICE, 8'h55);
    wr(`WTC_OFS_SERVICE, 8'h55);
    wr(`WTC_OFS_SERVICE, 8'hAA);
    repeat (6000) @(posedge core_clk);
    wr(`WTC_OFS_SERVICE, 8'h55);
    wr(`WTC_OFS_SERVICE, 8'hAA);
    wait_hi(1, 9000);
    cmpn("wd restart", 8191, 8193, n);
    wr(`WTC_OFS_SERVICE, 8'h12);
    cmp("wd bad", 8'h01, {7'h00, watchdog_reset});
    wr(`WTC_OFS_SUP_CTL, 8'h80);
    wr(`WTC_OFS_SUP_CTL, 8'h7F);
    rd(`WTC_OFS_SUP_CTL, 8'h00);
    wr(`WTC_OFS_SUP_CTL, 8'h80);
    rd(`WTC_OFS_SUP_CTL, 8'h80);
    rc_timeout_pin <= 1'b1;
    wait_hi(2, 8);
    cmpn("cm latency", 3, 5, n);
    wr(`WTC_OFS_SUP_CTL, 8'h00);
    @(posedge core_clk);
    cmp("cm off", 8'h00, {7'h00, monitor_reset});
    rc_timeout_pin <= 1'b0;
    $display("test watchdog done");
    wr(`WTC_OFS_TICK_CTL, 8'hE9);
    wr(`WTC_OFS_TICK_CTL, 8'h89);
    rd(`WTC_OFS_TICK_CTL, 8'hE1);
    wait_hi(0, 8400);
    wr(`WTC_OFS_TICK_FLAG, 8'h80);
    wait_hi(0, 8400);
    cmpn("tick normal", 8191, 8193, n + 2);
    rd(`WTC_OFS_TICK_FLAG, 8'h80);
    wr(`WTC_OFS_TICK_FLAG, 8'h00);
    rd(`WTC_OFS_TICK_FLAG, 8'h80);
    wr(`WTC_OFS_TICK_FLAG, 8'h80);
    cmp("irq clear", 8'h00, {7'h00, tick_irq});
    $display("test tick done");
    do_reset(1'b1);
    base = 5'h1F;
    reg_base <= 5'h1F;
    rd(`WTC_OFS_SUP_CTL, 8'h01);
    wait_mode <= 1'b1;
    for (int x = 0; x < 8; x++)
    begin
      wr(`WTC_OFS_WAIT_DIV, x[7:0]);
      repeat (8) @(posedge core_clk);
      n = 0;
      repeat (128)
      begin
        @(posedge core_clk);
        n += int'(bus_clk_enable === 1'b1);
      end
      cmpn("slow", 128 >> x, 128 >> x, n);
    end
    wait_mode <= 1'b0;
    wr(`WTC_OFS_TICK_CTL, 8'hE9);
    wr(`WTC_OFS_TICK_CTL, 8'h0A);
    rd(`WTC_OFS_TICK_CTL, 8'h0A);
    for (int r = 1; r < 8; r++)
    begin
      wr(`WTC_OFS_TICK_CTL, 8'h88 | r[7:0]);
      wait_hi(0, 1 << (r + 3));
      wr(`WTC_OFS_TICK_FLAG, 8'h80);
      wait_hi(0, 1 << (r + 3));
      cmpn("tick bypass", (2 << r) - 1, (2 << r) + 1, n + 2);
      wr(`WTC_OFS_TICK_FLAG, 8'h80);
    end
    wr(`WTC_OFS_TICK_CTL, 8'hE9);
    for (int k = 0; k < 2; k++)
    begin
      wait_hi(0, 16);
      wait_mode <= (k == 0);
      debug_mode <= (k == 1);
      wr(`WTC_OFS_TICK_FLAG, 8'h80);
      repeat (40) @(posedge core_clk);
      cmp("halted irq", 8'h00, {7'h00, tick_irq});
      wait_mode <= 1'b0;
      debug_mode <= 1'b0;
    end
    wait_hi(0, 16);
    for (int c = 1; c < 8; c++)
    begin
      p = 1 << (st[c] - 11);
      wr(`WTC_OFS_SUP_CTL, c[7:0]);
      wait_hi(1, 9000);
      @(posedge core_clk);
      wait_hi(1, 9000);
      cmpn("wd rate", p - 1, p + 1, n + 1);
    end
    $display("test bypass done");
    wr(`WTC_OFS_TICK_CTL, 8'h00);
    wr(`WTC_OFS_SUP_CTL, 8'h17);
    @(posedge core_clk);
    cmp("force wd", 8'h01, {7'h00, watchdog_reset});
    wr(`WTC_OFS_SUP_CTL, 8'h1F);
    @(posedge core_clk);
    cmp("disable wd", 8'h00, {7'h00, watchdog_reset});
    wr(`WTC_OFS_SUP_CTL, 8'hA7);
    @(posedge core_clk);
    cmp("force cm", 8'h01, {7'h00, monitor_reset});
    wr(`WTC_OFS_SUP_CTL, 8'hAF);
    @(posedge core_clk);
    cmp("disable cm", 8'h00, {7'h00, monitor_reset});
    wr(`WTC_OFS_SERVICE, 8'h12);
    cmp("disable bad", 8'h00, {7'h00, watchdog_reset});
    $display("test force done");
    results();
  end
endmodule : tb

bind wtc_top wtc_monitor u_mon (.core_clk(core_clk), .rst(rst),
  .reg_base(reg_base), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .special_mode(special_mode), .wait_mode(wait_mode),
  .debug_mode(debug_mode), .rc_timeout_pin(rc_timeout_pin),
  .tick_irq(tick_irq), .watchdog_reset(watchdog_reset),
  .monitor_reset(monitor_reset), .bus_clk_enable(bus_clk_enable));
